/* File: verilog/icbp_pkg.sv */
// Shared constants and types for the CPU bus port of the S/T controller.
package icbp_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Bus style of the host port.
  typedef enum logic [1:0] {
    ICBP_STYLE_MUX = 2'b00,
    ICBP_STYLE_SEP = 2'b01,
    ICBP_STYLE_DS  = 2'b10
  } icbp_style_t;

  // Host sequencer states.
  typedef enum logic [2:0] {
    ICBP_H_IDLE   = 3'b000,
    ICBP_H_ALE    = 3'b001,
    ICBP_H_SETUP  = 3'b010,
    ICBP_H_STROBE = 3'b011,
    ICBP_H_END    = 3'b100,
    ICBP_H_RST    = 3'b101
  } icbp_hstate_t;

  localparam int CLK_PERIOD_NS = 8;
  localparam int ALE_WIDTH_NS  = 40;
  localparam int ADDR_SETUP_NS = 10;
  localparam int ADDR_HOLD_NS  = 10;
  localparam int ALE_CYCLES        = (ALE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_SETUP_CYCLES = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_CYCLES  = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES     = 4;
  localparam int RESET_DCL_PERIODS = 4;
  localparam int DCL_PERIOD_NS_DEF = 1000;
  localparam int WAKE_RST_CYCLES   = 16;
  localparam int CNT_W             = 16;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hff;
endpackage

/* File: verilog/icbp_bus_if.sv */
// Pin-level carrier between the host end and the device end of the CPU bus port.
`timescale 1ns/1ps
interface icbp_bus_if;
  import icbp_pkg::*;
  logic              chip_select_n;           // Active-low chip select from host.
  logic              write_or_direction_in;   // Write strobe or read/write direction.
  logic              read_or_data_strobe_in;  // Read strobe or data strobe.
  logic              addr_latch_in;           // Address latch enable.
  logic [ADDR_W-1:0] addr_pins;               // Bit 0 is addr_bit_zero, bit 5 addr_bit_top.
  logic [DATA_W-1:0] host_data_out;           // Host drive value on the shared bus.
  logic              host_data_oe;            // Host drives the shared bus.
  logic [DATA_W-1:0] dev_data_out;            // Device drive value on the shared bus.
  logic              dev_data_oe;             // Device drives the shared bus.
  logic [DATA_W-1:0] shared_bus;              // Resolved level, bit 0 is shared_bus_bit0.
  logic              irq_out;                 // Device drive value on the interrupt line.
  logic              irq_oe;                  // Device pulls the interrupt line.
  logic              irq_request_n;           // Resolved interrupt line, pulled up.
  logic              host_rst_out;            // Host drive value on the reset pin.
  logic              host_rst_oe;             // Host drives the reset pin.
  logic              dev_rst_out;             // Device drive value on the reset pin.
  logic              dev_rst_oe;              // Device drives the reset pin.
  logic              reset_pin;               // Resolved reset pin, pulled down.

  assign shared_bus    = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : BUS_IDLE);
  assign irq_request_n = (irq_oe && !irq_out) ? 1'b0 : 1'b1;
  assign reset_pin     = (host_rst_oe & host_rst_out) | (dev_rst_oe & dev_rst_out);

  modport dev (
    input  chip_select_n, write_or_direction_in, read_or_data_strobe_in, addr_latch_in,
    input  addr_pins, shared_bus, reset_pin,
    output dev_data_out, dev_data_oe, irq_out, irq_oe, dev_rst_out, dev_rst_oe
  );
  modport host (
    output chip_select_n, write_or_direction_in, read_or_data_strobe_in, addr_latch_in,
    output addr_pins, host_data_out, host_data_oe, host_rst_out, host_rst_oe,
    input  shared_bus, irq_request_n, reset_pin
  );
endinterface

/* File: verilog/icbp_host.sv */
// Host end: an 8-bit processor bus master that drives the CPU bus port.
`timescale 1ns/1ps
module icbp_host #(
  parameter int DCL_PERIOD_NS = icbp_pkg::DCL_PERIOD_NS_DEF
) (
  input  wire logic                        sys_clk,     // System clock.
  input  wire logic                        reset,       // Synchronous reset, high.
  icbp_bus_if.host                         bus,         // Pins toward the device.
  input  wire icbp_pkg::icbp_style_t       style,       // Bus style to use.
  input  wire logic                        cmd_valid,   // Access request.
  input  wire logic                        cmd_write,   // 1 write, 0 read.
  input  wire logic [icbp_pkg::ADDR_W-1:0] cmd_addr,    // Register address.
  input  wire logic [icbp_pkg::DATA_W-1:0] cmd_wdata,   // Write data.
  output logic                             cmd_ready,   // Request taken when high.
  output logic                             rsp_valid,   // One-cycle completion pulse.
  output logic [icbp_pkg::DATA_W-1:0]      rsp_rdata,   // Read data.
  input  wire logic                        rst_req,     // Request a device reset pulse.
  input  wire logic                        wake_level,  // Level for addr_bit_top when idle.
  output logic                             irq_seen     // Interrupt line is low.
);
  import icbp_pkg::*;

  localparam int RST_CYCLES =
    (RESET_DCL_PERIODS * DCL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  icbp_hstate_t      st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              cs_n_q, cs_n_d, wr_q, wr_d, rd_q, rd_d, ale_q, ale_d;
  logic              oe_q, oe_d, rst_q, rst_d, we_q, we_d, rv_q, rv_d;
  logic [DATA_W-1:0] dout_q, dout_d, wd_q, wd_d, rdat_q, rdat_d;
  logic [ADDR_W-1:0] a_q, a_d;
  icbp_style_t       sty_q, sty_d;

  assign cmd_ready = (st_q == ICBP_H_IDLE) && !rst_req;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rdat_q;
  assign irq_seen  = !bus.irq_request_n;

  assign bus.chip_select_n          = cs_n_q;
  assign bus.write_or_direction_in  = wr_q;
  assign bus.read_or_data_strobe_in = rd_q;
  assign bus.addr_latch_in          = ale_q;
  assign bus.addr_pins = (st_q == ICBP_H_IDLE) ? {wake_level, a_q[ADDR_W-2:0]} : a_q;
  assign bus.host_data_out = dout_q;
  assign bus.host_data_oe  = oe_q;
  assign bus.host_rst_out  = rst_q;
  assign bus.host_rst_oe   = rst_q;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    cs_n_d = cs_n_q;
    wr_d   = wr_q;
    rd_d   = rd_q;
    ale_d  = ale_q;
    oe_d   = oe_q;
    rst_d  = rst_q;
    we_d   = we_q;
    wd_d   = wd_q;
    a_d    = a_q;
    sty_d  = sty_q;
    dout_d = dout_q;
    rdat_d = rdat_q;
    rv_d   = 1'b0;
    unique case (st_q)
      ICBP_H_IDLE: begin
        if (rst_req) begin
          st_d  = ICBP_H_RST;
          rst_d = 1'b1;
          cnt_d = CNT_W'(RST_CYCLES - 1);
        end else if (cmd_valid) begin
          we_d  = cmd_write;
          wd_d  = cmd_wdata;
          sty_d = style;
          if (style == ICBP_STYLE_MUX) begin
            st_d   = ICBP_H_ALE;
            ale_d  = 1'b1;
            oe_d   = 1'b1;
            dout_d = DATA_W'(cmd_addr);
            a_d    = '0;
            cnt_d  = CNT_W'(ALE_CYCLES - 1);
          end else begin
            st_d  = ICBP_H_SETUP;
            a_d   = cmd_addr;
            cnt_d = CNT_W'(ADDR_SETUP_CYCLES - 1);
            if (style == ICBP_STYLE_DS) begin
              wr_d = !cmd_write;
            end
          end
        end
      end
      ICBP_H_ALE: begin
        if (cnt_q == '0) begin
          st_d  = ICBP_H_SETUP;
          ale_d = 1'b0;
          cnt_d = CNT_W'(ADDR_HOLD_CYCLES - 1);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ICBP_H_SETUP: begin
        if (cnt_q == '0) begin
          st_d   = ICBP_H_STROBE;
          cs_n_d = 1'b0;
          cnt_d  = CNT_W'(STROBE_CYCLES - 1);
          oe_d   = we_q;
          dout_d = wd_q;
          if (sty_q == ICBP_STYLE_DS) begin
            rd_d = 1'b0;
          end else if (we_q) begin
            wr_d = 1'b0;
          end else begin
            rd_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ICBP_H_STROBE: begin
        if (cnt_q == '0) begin
          st_d = ICBP_H_END;
          rd_d = 1'b1;
          if (sty_q != ICBP_STYLE_DS) begin
            wr_d = 1'b1;
          end
          if (!we_q) begin
            rdat_d = bus.shared_bus;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ICBP_H_END: begin
        st_d   = ICBP_H_IDLE;
        cs_n_d = 1'b1;
        oe_d   = 1'b0;
        wr_d   = 1'b1;
        rv_d   = 1'b1;
      end
      ICBP_H_RST: begin
        if (cnt_q == '0) begin
          st_d  = ICBP_H_IDLE;
          rst_d = 1'b0;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d = ICBP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q   <= ICBP_H_IDLE;
      cnt_q  <= '0;
      cs_n_q <= 1'b1;
      wr_q   <= 1'b1;
      rd_q   <= 1'b1;
      ale_q  <= 1'b0;
      oe_q   <= 1'b0;
      rst_q  <= 1'b0;
      we_q   <= 1'b0;
      wd_q   <= '0;
      a_q    <= '0;
      sty_q  <= ICBP_STYLE_MUX;
      dout_q <= '0;
      rdat_q <= '0;
      rv_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      cs_n_q <= cs_n_d;
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      ale_q  <= ale_d;
      oe_q   <= oe_d;
      rst_q  <= rst_d;
      we_q   <= we_d;
      wd_q   <= wd_d;
      a_q    <= a_d;
      sty_q  <= sty_d;
      dout_q <= dout_d;
      rdat_q <= rdat_d;
      rv_q   <= rv_d;
    end
  end
endmodule

/* File: verilog/icbp_device.sv */
// Device end: register access port, interrupt line, reset pin and wake input.
`timescale 1ns/1ps
module icbp_device #(
  parameter int WAKE_RST_CYCLES = icbp_pkg::WAKE_RST_CYCLES
) (
  input  wire logic                        sys_clk,         // System clock.
  input  wire logic                        reset,           // Synchronous reset, high.
  icbp_bus_if.dev                          bus,             // Pins toward the host.
  input  wire logic                        ds_style,        // Non-mux: 1 direction+strobe.
  input  wire logic                        terminal_fn_en,  // Terminal functions enabled.
  input  wire logic                        irq_pending,     // Core interrupt pending.
  input  wire logic                        wake_clear,      // Clears the wake flag.
  input  wire logic [icbp_pkg::DATA_W-1:0] reg_rdata,       // Core read data.
  output logic [icbp_pkg::ADDR_W-1:0]      reg_addr,        // Access address.
  output logic [icbp_pkg::DATA_W-1:0]      reg_wdata,       // Write data.
  output logic                             reg_we,          // One-cycle write pulse.
  output logic                             reg_re,          // One-cycle read pulse.
  output logic                             mux_mode,        // Multiplexed mode seen.
  output logic                             wake_flag,       // Sticky wake event.
  output logic                             core_reset       // Device reset state.
);
  import icbp_pkg::*;

  localparam int RC_W = $clog2(WAKE_RST_CYCLES + 1);

  logic              core_rst;
  logic              cs;
  logic              sep_strobes;
  logic              rd_stb;
  logic              wr_stb;
  logic              acc_start;
  logic [ADDR_W-1:0] eff_addr;
  logic              wake_fall;

  logic              mux_q;
  logic              mux_d;
  logic [ADDR_W-1:0] alat_q;
  logic [ADDR_W-1:0] alat_d;
  logic              rd_act_q;
  logic              rd_act_d;
  logic              wr_act_q;
  logic              wr_act_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              we_q;
  logic              we_d;
  logic              re_q;
  logic              re_d;

  logic              top_q;
  logic              top_d;
  logic              wake_q;
  logic              wake_d;
  logic              crst_q;
  logic              crst_d;
  logic [RC_W-1:0]   rcnt_q;
  logic [RC_W-1:0]   rcnt_d;

  assign core_rst = reset | bus.reset_pin;

  always_comb begin
    cs    = !bus.chip_select_n;
    // Multiplexed mode always uses separate read and write strobes.
    sep_strobes = mux_q || !ds_style;
    if (sep_strobes) begin
      rd_stb = cs && !bus.read_or_data_strobe_in;
      wr_stb = cs && !bus.write_or_direction_in;
    end else begin
      rd_stb = cs && !bus.read_or_data_strobe_in && bus.write_or_direction_in;
      wr_stb = cs && !bus.read_or_data_strobe_in && !bus.write_or_direction_in;
    end
    acc_start = (rd_stb && !rd_act_q) || (wr_stb && !wr_act_q);
  end

  always_comb begin
    if (mux_q) begin
      eff_addr = alat_q;
    end else begin
      eff_addr = bus.addr_pins;
      if (terminal_fn_en) begin
        eff_addr[ADDR_W-1] = 1'b0;
      end
    end
  end

  // Mode and address latch: one sight of the latch enable picks multiplexed mode.
  always_comb begin
    mux_d  = mux_q || bus.addr_latch_in;
    alat_d = bus.addr_latch_in ? bus.shared_bus[ADDR_W-1:0] : alat_q;
  end

  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      mux_q  <= 1'b0;
      alat_q <= '0;
    end else begin
      mux_q  <= mux_d;
      alat_q <= alat_d;
    end
  end

  always_comb begin
    rd_act_d = rd_stb;
    wr_act_d = wr_stb;
    addr_d   = acc_start ? eff_addr : addr_q;
    wdata_d  = wr_stb ? bus.shared_bus : wdata_q;
    // A write closes as its strobe ends; a read pulses as its strobe starts, whichever style.
    we_d     = wr_act_q && !wr_stb;
    re_d     = rd_stb && !rd_act_q;
    rdata_d  = rd_stb ? reg_rdata : rdata_q;
  end

  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      addr_q   <= '0;
      wdata_q  <= '0;
      we_q     <= 1'b0;
      re_q     <= 1'b0;
      rdata_q  <= '0;
    end else begin
      rd_act_q <= rd_act_d;
      wr_act_q <= wr_act_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      we_q     <= we_d;
      re_q     <= re_d;
      rdata_q  <= rdata_d;
    end
  end

  // Wake logic and the reset pulse run on the plain reset only, so that the
  // pulse this block drives onto the reset pin does not cut itself short.
  // The edge detector starts low, so a low wake line after reset is no edge.
  always_comb begin
    top_d     = bus.addr_pins[ADDR_W-1];
    wake_fall = terminal_fn_en && top_q && !bus.addr_pins[ADDR_W-1];
    // A wake event in the same cycle as a clear keeps the flag set.
    wake_d    = wake_fall || (wake_q && !wake_clear);
    crst_d    = bus.reset_pin;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      top_q  <= 1'b0;
      wake_q <= 1'b0;
      crst_q <= 1'b1;
    end else begin
      top_q  <= top_d;
      wake_q <= wake_d;
      crst_q <= crst_d;
    end
  end

  // Reset pulse length counter, loaded again by each wake event.
  always_comb begin
    if (wake_fall) begin
      rcnt_d = RC_W'(WAKE_RST_CYCLES);
    end else if (rcnt_q != '0) begin
      rcnt_d = rcnt_q - 1'b1;
    end else begin
      rcnt_d = rcnt_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rcnt_q <= '0;
    end else begin
      rcnt_q <= rcnt_d;
    end
  end

  assign bus.dev_data_out = rdata_q;
  assign bus.dev_data_oe  = rd_stb && !core_rst;
  assign bus.irq_out      = 1'b0;
  assign bus.irq_oe       = irq_pending || wake_q;
  assign bus.dev_rst_out  = 1'b1;
  assign bus.dev_rst_oe   = terminal_fn_en && (rcnt_q != '0);

  assign reg_addr   = addr_q;
  assign reg_wdata  = wdata_q;
  assign reg_we     = we_q;
  assign reg_re     = re_q;
  assign mux_mode   = mux_q;
  assign wake_flag  = wake_q;
  assign core_reset = crst_q;
endmodule

/* File: verification/icbp_props.sv */
// Concurrent checks on the pins between the host end and the device end.
`timescale 1ns/1ps
module icbp_props #(
  parameter int WAKE_RST_CYCLES = 16
) (
  input wire logic sys_clk,                 // System clock.
  input wire logic reset,                   // Synchronous reset, high.
  input wire logic chip_select_n,           // Chip select, low.
  input wire logic write_or_direction_in,   // Write strobe or direction.
  input wire logic read_or_data_strobe_in,  // Read strobe or data strobe.
  input wire logic addr_latch_in,           // Address latch enable.
  input wire logic host_data_oe,            // Host drives the bus.
  input wire logic dev_data_oe,             // Device drives the bus.
  input wire logic irq_out,                 // Interrupt drive value.
  input wire logic irq_oe,                  // Interrupt pull enable.
  input wire logic dev_rst_out,             // Device reset drive value.
  input wire logic dev_rst_oe,              // Device drives the reset pin.
  input wire logic reset_pin                // Resolved reset pin.
);
  logic [15:0] run_q;
  logic [15:0] run_d;

  // Length of the current device reset pulse in cycles.
  always_comb begin
    run_d = dev_rst_oe ? run_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk) begin
    run_q <= reset ? 16'h0000 : run_d;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_cs_high_quiet: assert property (
    chip_select_n |-> !dev_data_oe) else $error("Bus driven while not selected.");
  a_read_drives_bus: assert property (
    (!chip_select_n && !read_or_data_strobe_in && write_or_direction_in && !reset_pin
     && !$past(reset_pin) && !$past(reset)) |-> dev_data_oe)
    else $error("Read cycle without bus drive.");
  a_write_no_drive: assert property (
    !write_or_direction_in |-> !dev_data_oe) else $error("Bus driven in a write cycle.");
  a_strobe_end_release: assert property (
    $rose(read_or_data_strobe_in) |-> !dev_data_oe) else $error("Bus held past strobe.");
  a_ale_no_drive: assert property (
    addr_latch_in |-> !dev_data_oe) else $error("Bus driven in address phase.");
  a_no_contention: assert property (
    host_data_oe |-> !dev_data_oe) else $error("Both ends drive the bus.");
  a_irq_open_drain: assert property (
    irq_oe |-> !irq_out) else $error("Interrupt line driven high.");
  a_reset_held: assert property (
    (reset_pin && $past(reset_pin)) |-> !dev_data_oe) else $error("Bus driven in reset.");
  a_wake_irq_pulse: assert property (
    $rose(dev_rst_oe) |-> (irq_oe && dev_rst_out)) else $error("Wake pulse without irq.");
  a_wake_pulse_len: assert property (
    $fell(dev_rst_oe) |-> (run_q == 16'(WAKE_RST_CYCLES)))
    else $error("Wake reset pulse length wrong.");
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench joining the host end and the device end of the CPU bus port.
`timescale 1ns/1ps
module tb_top;
  import icbp_pkg::*;
  localparam int DCL_NS = 16;
  localparam int WAKE_CYC = 4;
  localparam icbp_style_t ST [3] = '{ICBP_STYLE_SEP, ICBP_STYLE_DS, ICBP_STYLE_MUX};
  // Edges from the take edge to the completion pulse: each phase, then the closing cycle.
  localparam int LAT_NM = ADDR_SETUP_CYCLES + STROBE_CYCLES + 1;
  localparam int LAT_MX = ALE_CYCLES + ADDR_HOLD_CYCLES + STROBE_CYCLES + 1;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  icbp_style_t       style = ICBP_STYLE_SEP;
  logic              cmd_valid = 1'b0;
  logic              cmd_write = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = 6'h00;
  logic [DATA_W-1:0] cmd_wdata = 8'h00;
  logic              cmd_ready, rsp_valid, irq_seen, reg_we, reg_re;
  logic [DATA_W-1:0] rsp_rdata, reg_wdata, wr_data;
  logic [ADDR_W-1:0] reg_addr, wr_addr;
  logic              rst_req = 1'b0;
  logic              wake_level = 1'b0;
  logic              ds_style = 1'b0;
  logic              terminal_fn_en = 1'b0;
  logic              irq_pending = 1'b0;
  logic              wake_clear = 1'b0;
  logic              mux_mode, wake_flag, core_reset;
  int                failures = 0;
  int                cmp_count = 0;
  int                we_cnt = 0;
  int                re_cnt = 0;
  int                cyc = 0;

  // Core register file model: a fixed pattern per address.
  function automatic logic [DATA_W-1:0] rd_exp(input logic [ADDR_W-1:0] a);
    return {2'b10, a} ^ 8'h33;
  endfunction

  icbp_bus_if i_icbp_bus_if ();
  icbp_host #(.DCL_PERIOD_NS(DCL_NS)) i_icbp_host (
    .sys_clk(sys_clk), .reset(reset), .bus(i_icbp_bus_if), .style(style),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rst_req(rst_req), .wake_level(wake_level), .irq_seen(irq_seen));
  icbp_device #(.WAKE_RST_CYCLES(WAKE_CYC)) i_icbp_device (
    .sys_clk(sys_clk), .reset(reset), .bus(i_icbp_bus_if), .ds_style(ds_style),
    .terminal_fn_en(terminal_fn_en), .irq_pending(irq_pending), .wake_clear(wake_clear),
    .reg_rdata(rd_exp(reg_addr)), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .mux_mode(mux_mode), .wake_flag(wake_flag),
    .core_reset(core_reset));
  icbp_props #(.WAKE_RST_CYCLES(WAKE_CYC)) i_icbp_props (
    .sys_clk(sys_clk), .reset(reset), .chip_select_n(i_icbp_bus_if.chip_select_n),
    .write_or_direction_in(i_icbp_bus_if.write_or_direction_in),
    .read_or_data_strobe_in(i_icbp_bus_if.read_or_data_strobe_in),
    .addr_latch_in(i_icbp_bus_if.addr_latch_in), .host_data_oe(i_icbp_bus_if.host_data_oe),
    .dev_data_oe(i_icbp_bus_if.dev_data_oe), .irq_out(i_icbp_bus_if.irq_out),
    .irq_oe(i_icbp_bus_if.irq_oe), .dev_rst_out(i_icbp_bus_if.dev_rst_out),
    .dev_rst_oe(i_icbp_bus_if.dev_rst_oe), .reset_pin(i_icbp_bus_if.reset_pin));

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (reg_we === 1'b1) begin
      we_cnt <= we_cnt + 1;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
    if (reg_re === 1'b1) begin
      re_cnt <= re_cnt + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      $display("Timeout at %0t", $time);
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One register access through the host end, checked at the device core side.
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input int lat);
    int n;
    int we0;
    int re0;
    n = 0;
    we0 = we_cnt;
    re0 = re_cnt;
    while (cmd_ready !== 1'b1) @(posedge sys_clk);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    while (n < 40 && rsp_valid !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n, lat);
    @(posedge sys_clk);
    #1;
    if (wr) begin
      check(we_cnt - we0, 1);
      check(32'({wr_addr, wr_data}), 32'({a, d}));
    end else begin
      check(re_cnt - re0, 1);
      check(32'({reg_addr, rsp_rdata}), 32'({a, rd_exp(a)}));
    end
  endtask

  // Measures how many cycles the reset pin stays high.
  task automatic pin_pulse(input int exp);
    int n;
    n = 0;
    #1;
    while (i_icbp_bus_if.reset_pin !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    n = 0;
    while (i_icbp_bus_if.reset_pin === 1'b1 && n < 600) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n, exp);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      style <= ST[s];
      ds_style <= (s == 1);
      access(1'b1, 6'h3f, 8'ha5, (s == 2) ? LAT_MX : LAT_NM);
      access(1'b0, 6'h00, 8'h00, (s == 2) ? LAT_MX : LAT_NM);
      access(1'b1, 6'h15, 8'h5a, (s == 2) ? LAT_MX : LAT_NM);
      access(1'b0, 6'h2a, 8'h00, (s == 2) ? LAT_MX : LAT_NM);
      check(mux_mode, s == 2);
      $display("Test of bus style %0d done", s);
    end
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    @(posedge sys_clk);
    #1;
    check({irq_seen, i_icbp_bus_if.irq_request_n}, 2'b10);
    @(posedge sys_clk);
    irq_pending <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(irq_seen, 1'b0);
    $display("Test of interrupt line done");
    @(posedge sys_clk);
    rst_req <= 1'b1;
    @(posedge sys_clk);
    rst_req <= 1'b0;
    pin_pulse(4 * DCL_NS / CLK_PERIOD_NS);
    @(posedge sys_clk);
    #1;
    check({mux_mode, core_reset}, 2'b00);
    $display("Test of reset pin done");
    @(posedge sys_clk);
    terminal_fn_en <= 1'b1;
    wake_level <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wake_level <= 1'b0;
    pin_pulse(WAKE_CYC);
    check({wake_flag, irq_seen}, 2'b11);
    @(posedge sys_clk);
    wake_clear <= 1'b1;
    @(posedge sys_clk);
    wake_clear <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({wake_flag, irq_seen}, 2'b00);
    $display("Test of wake line done");
    end_of_test();
  end
endmodule
